// [tb/afq_host_model.sv]
// Register bus host model, strobes launched at the falling edge
`timescale 1ns/1ps
`default_nettype none
module afq_host_model
	import afq_pkg::*;
(
	input wire logic i_ref_clk,
	input wire afq_byte_t i_rdata,
	output logic o_wr,
	output logic o_rd,
	output afq_byte_t o_addr,
	output afq_byte_t o_wdata
);
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'hFF;
		o_wdata = 8'h00;
	end
	task automatic access(input logic w, input afq_byte_t a,
		input afq_byte_t d, output afq_byte_t q);
		@(negedge i_ref_clk);
		o_wr = w;
		o_rd = !w;
		o_addr = a;
		o_wdata = d;
		@(negedge i_ref_clk);
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
		@(negedge i_ref_clk);
		q = i_rdata;
	endtask
endmodule // afq_host_model
`default_nettype wire

// [tb/alert_mask_fault_queue_tb_top.sv]
// Self-checking bench for the alert mask and fault queue block
`timescale 1ns/1ps
`default_nettype none
module alert_mask_fault_queue_tb_top;
	import afq_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr, rd, tv, al, ac, fo, dr, df;
	afq_byte_t addr, wd, rdata, temp, q;
	logic [9:1] sv, so;
	logic [9:0] st;
	int num_errors = 0;
	int checks = 0;
	afq_byte_t ra [7] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h05};
	afq_byte_t rv [7] = '{8'h01, 8'h09, 8'h52, 8'h10, 8'h00, 8'h8B, 8'h00};
	afq_byte_t rw [7] = '{8'h0F, 8'h4B, 8'hFA, 8'h1C, 8'hC0, 8'hFF, 8'h00};
	afq_byte_t fq [4] = '{8'h01, 8'h03, 8'h07, 8'h0F};
	afq_byte_t ma [10] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h09, 8'h09,
		8'h09, 8'h0A, 8'h0A};
	afq_byte_t mb [10] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h10, 8'h08,
		8'h04, 8'h80, 8'h40};
	always #25 clk = ~clk;
	afq_host_model u_host (.i_ref_clk(clk), .i_rdata(rdata), .o_wr(wr),
		.o_rd(rd), .o_addr(addr), .o_wdata(wd));
	afq_alert_mask u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd),
		.i_local_temp_valid(tv), .i_local_temp(temp), .i_src_valid(sv),
		.i_src_out_of_limit(so), .o_reg_rdata(rdata), .o_status(st),
		.o_alert(al), .o_alert_comp(ac), .o_fan_off(fo),
		.o_drive_remote(dr), .o_drive_full(df));
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input afq_byte_t a, input afq_byte_t e);
		u_host.access(1'b0, a, 8'h00, q);
		chk({2'h0, q}, {2'h0, e});
	endtask
	task automatic wrr(input afq_byte_t a, input afq_byte_t d);
		u_host.access(1'b1, a, d, q);
	endtask
	task automatic meas(input int g, input logic bad);
		@(negedge clk);
		tv = (g == 0);
		temp = bad ? 8'h81 : 8'h80;
		sv = 9'((10'h001 << g) >> 1);
		so = bad ? sv : 9'h000;
		@(negedge clk);
		tv = 1'b0;
		temp = ~temp;
		sv = 9'h000;
		so = 9'h000;
		repeat (2) @(negedge clk);
	endtask
	task automatic test_done;
		$display("Errors %0d, checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		tv = 1'b0;
		temp = 8'h00;
		sv = 9'h000;
		so = 9'h000;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		for (int i = 0; i < 7; i++) rdc(ra[i], rv[i]);
		for (int i = 0; i < 7; i++) wrr(ra[i], 8'hFF);
		chk({fo, df, dr}, 3'b110);
		for (int i = 0; i < 7; i++) rdc(ra[i], rw[i]);
		wrr(8'h01, 8'h01);
		rdc(8'h01, 8'h00);
		for (int i = 0; i < 7; i++) rdc(ra[i], i == 5 ? 8'hFF : rv[i]);
		chk({fo, df, dr}, 3'b001);
		for (int d = 0; d < 4; d++) begin
			wrr(8'h07, 8'(d));
			chk({df, dr}, {d == 3, d == 1 || d == 2});
		end
		wrr(8'h08, 8'h00);
		for (int n = 1; n < 5; n++) begin
			wrr(8'h06, fq[n-1]);
			repeat (n - 1) meas(2, 1'b1);
			meas(2, 1'b0);
			repeat (n - 1) meas(2, 1'b1);
			chk({st[2], al}, 2'b00);
			meas(2, 1'b1);
			chk({st[2], al}, 2'b11);
			meas(2, 1'b0);
			chk({st[2], al}, 2'b00);
		end
		wrr(8'h06, 8'h01);
		wrr(8'h0B, 8'h80);
		for (int g = 0; g < 10; g++) begin
			for (int r = 8; r < 11; r++) wrr(8'(r), 8'hFF);
			meas(g, 1'b1);
			chk({st[g], al, ac}, {2'b10, g == 7});
			wrr(ma[g], 8'hFF ^ mb[g]);
			chk({al, ac}, 2'b11);
			meas(g, 1'b0);
			chk(st[g], 1'b0);
		end
		meas(9, 1'b1);
		chk({st[9], al}, 2'b11);
		wrr(8'h01, 8'h01);
		rdc(8'h0A, 8'h00);
		chk({st[9], al}, 2'b00);
		test_done();
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		test_done();
	end
endmodule // alert_mask_fault_queue_tb_top
`default_nettype wire

// [verilog/afq_alert_mask.sv]
// Alert mask, fault queue and fan behaviour register block
`timescale 1ns/1ps
`default_nettype none
`include "afq_consts.svh"
module afq_alert_mask
	import afq_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire afq_byte_t i_reg_addr,
	input wire afq_byte_t i_reg_wdata,
	input wire logic i_local_temp_valid,
	input wire afq_byte_t i_local_temp,
	input wire logic [`AFQ_NUM_SRC-1:1] i_src_valid,
	input wire logic [`AFQ_NUM_SRC-1:1] i_src_out_of_limit,
	output afq_byte_t o_reg_rdata,
	output logic [`AFQ_NUM_SRC-1:0] o_status,
	output logic o_alert,
	output logic o_alert_comp,
	output logic o_fan_off,
	output logic o_drive_remote,
	output logic o_drive_full
);
	afq_byte_t fq_ff, fan_ff, msk1_ff, msk2_ff, msk3_ff, lhl_ff, rdata_ff;
	logic swrst_ff, alert_ff, comp_ff, fan_off_ff, remote_ff, full_ff;
	wire logic [`AFQ_NUM_SRC-1:0] ev;

	wire logic wr_swrst = i_reg_wr && (i_reg_addr == `AFQ_ADDR_SWRST);
	wire logic wr_fq = i_reg_wr && (i_reg_addr == `AFQ_ADDR_FQ);
	wire logic wr_fan = i_reg_wr && (i_reg_addr == `AFQ_ADDR_FAN);
	wire logic wr_msk1 = i_reg_wr && (i_reg_addr == `AFQ_ADDR_MSK1);
	wire logic wr_msk2 = i_reg_wr && (i_reg_addr == `AFQ_ADDR_MSK2);
	wire logic wr_msk3 = i_reg_wr && (i_reg_addr == `AFQ_ADDR_MSK3);
	wire logic wr_lhl = i_reg_wr && (i_reg_addr == `AFQ_ADDR_LHL);

	function automatic afq_byte_t merge(afq_byte_t old, afq_byte_t wd,
			afq_byte_t wm);
		merge = (wd & wm) | (old & ~wm);
	endfunction

	// Software reset wins over a write in the same cycle; the local high limit is not reset and takes the write
	wire afq_byte_t nxt_fq = swrst_ff ? `AFQ_RST_FQ :
		wr_fq ? merge(fq_ff, i_reg_wdata, `AFQ_WM_FQ) : fq_ff;
	wire afq_byte_t nxt_fan = swrst_ff ? `AFQ_RST_FAN :
		wr_fan ? merge(fan_ff, i_reg_wdata, `AFQ_WM_FAN) : fan_ff;
	wire afq_byte_t nxt_msk1 = swrst_ff ? `AFQ_RST_MSK1 :
		wr_msk1 ? merge(msk1_ff, i_reg_wdata, `AFQ_WM_MSK1) : msk1_ff;
	wire afq_byte_t nxt_msk2 = swrst_ff ? `AFQ_RST_MSK2 :
		wr_msk2 ? merge(msk2_ff, i_reg_wdata, `AFQ_WM_MSK2) : msk2_ff;
	wire afq_byte_t nxt_msk3 = swrst_ff ? `AFQ_RST_MSK3 :
		wr_msk3 ? merge(msk3_ff, i_reg_wdata, `AFQ_WM_MSK3) : msk3_ff;
	wire afq_byte_t nxt_lhl = wr_lhl ? i_reg_wdata : lhl_ff;
	wire logic nxt_swrst = wr_swrst && i_reg_wdata[`AFQ_BIT_SWRST] &&
		!swrst_ff;

	wire afq_byte_t rd_mux =
		(i_reg_addr == `AFQ_ADDR_SWRST) ? {7'h00, swrst_ff} :
		(i_reg_addr == `AFQ_ADDR_FQ) ? fq_ff :
		(i_reg_addr == `AFQ_ADDR_FAN) ? fan_ff :
		(i_reg_addr == `AFQ_ADDR_MSK1) ? msk1_ff :
		(i_reg_addr == `AFQ_ADDR_MSK2) ? msk2_ff :
		(i_reg_addr == `AFQ_ADDR_MSK3) ? msk3_ff :
		(i_reg_addr == `AFQ_ADDR_LHL) ? lhl_ff : `AFQ_RD_ZERO;
	wire afq_byte_t nxt_rdata = i_reg_rd ? rd_mux : rdata_ff;

	// Queue length decode: 000x=1, 001x=2, 01xx=3, 1xxx=4
	wire afq_count_t queue_len = fq_ff[3] ? 3'h4 : fq_ff[2] ? 3'h3 :
		fq_ff[1] ? 3'h2 : 3'h1;

	// Source order: local high/low, remote high/low, diode error,
	// throttle percent/assert/state, fan stalled, fan alarm speed
	wire logic [`AFQ_NUM_SRC-1:0] src_mask = {msk3_ff[6], msk3_ff[7],
		msk2_ff[2], msk2_ff[3], msk2_ff[4], msk1_ff[3], msk1_ff[4],
		msk1_ff[5], msk1_ff[6], msk1_ff[7]};
	wire logic [`AFQ_NUM_SRC-1:0] comp_mask = src_mask &
		~(`AFQ_NUM_SRC'(1) << `AFQ_SRC_THROTTLE_STATE);
	wire logic [`AFQ_NUM_SRC-1:0] all_valid = {i_src_valid,
		i_local_temp_valid};
	wire logic [`AFQ_NUM_SRC-1:0] all_ool = {i_src_out_of_limit,
		(i_local_temp > lhl_ff)};
	wire logic nxt_alert = |(ev & ~src_mask);
	wire logic nxt_comp = |(ev & ~comp_mask);
	wire afq_drive_src_t drv = afq_drive_src_t'(fan_ff[1:0]);
	wire logic nxt_remote = (drv == AFQ_DRV_REMOTE_A) ||
		(drv == AFQ_DRV_REMOTE_B);
	wire logic nxt_full = (drv == AFQ_DRV_FULL);

	genvar g;
	generate
		for (g = 0; g < `AFQ_NUM_SRC; g++) begin : g_src
			afq_fault_counter u_cnt (
				.i_ref_clk(i_ref_clk),
				.i_rst_n(i_rst_n),
				.i_clear(swrst_ff),
				.i_valid(all_valid[g]),
				.i_out_of_limit(all_ool[g]),
				.i_queue_len(queue_len),
				.o_event(ev[g])
			);
		end
	endgenerate

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fq_ff <= `AFQ_RST_FQ;
			fan_ff <= `AFQ_RST_FAN;
			msk1_ff <= `AFQ_RST_MSK1;
			msk2_ff <= `AFQ_RST_MSK2;
			msk3_ff <= `AFQ_RST_MSK3;
			lhl_ff <= `AFQ_RST_LHL;
			swrst_ff <= 1'b0;
			rdata_ff <= `AFQ_RD_ZERO;
		end else begin
			fq_ff <= nxt_fq;
			fan_ff <= nxt_fan;
			msk1_ff <= nxt_msk1;
			msk2_ff <= nxt_msk2;
			msk3_ff <= nxt_msk3;
			lhl_ff <= nxt_lhl;
			swrst_ff <= nxt_swrst;
			rdata_ff <= nxt_rdata;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			alert_ff <= 1'b0;
			comp_ff <= 1'b0;
			fan_off_ff <= 1'b0;
			remote_ff <= 1'b0;
			full_ff <= 1'b0;
		end else begin
			alert_ff <= nxt_alert;
			comp_ff <= nxt_comp;
			fan_off_ff <= fan_ff[`AFQ_BIT_FAN_OFF];
			remote_ff <= nxt_remote;
			full_ff <= nxt_full;
		end
	end

	assign o_reg_rdata = rdata_ff;
	assign o_status = ev;
	assign o_alert = alert_ff;
	assign o_alert_comp = comp_ff;
	assign o_fan_off = fan_off_ff;
	assign o_drive_remote = remote_ff;
	assign o_drive_full = full_ff;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_swrst_req;
		wr_swrst && i_reg_wdata[`AFQ_BIT_SWRST] && !swrst_ff;
	endsequence
	sequence s_swrst_done;
		swrst_ff ##1 !swrst_ff;
	endsequence

	a_swrst_selfclear: assert property (
		s_swrst_req |=> s_swrst_done)
		else $error("software reset bit did not pulse and clear");
	a_fq_default: assert property (
		swrst_ff |=> fq_ff == `AFQ_RST_FQ && fq_ff[7:4] == 4'h0)
		else $error("fault queue not restored by software reset");
	a_mask_defaults: assert property (
		swrst_ff |=> msk1_ff == `AFQ_RST_MSK1 && msk3_ff == `AFQ_RST_MSK3)
		else $error("mask registers not restored by software reset");
	a_limit_kept: assert property (
		swrst_ff && !wr_lhl |=> $stable(lhl_ff))
		else $error("local high limit changed by software reset");
	a_fan_off_out: assert property (
		wr_fan && !swrst_ff && i_reg_wdata[`AFQ_BIT_FAN_OFF] |=> ##1 o_fan_off)
		else $error("fan off bit did not stop the fan");
	a_drive_full: assert property (
		fan_ff[1:0] == 2'h3 |=> o_drive_full && !o_drive_remote)
		else $error("drive select 11 did not force full speed");
	a_mask_blocks: assert property (
		(ev & ~src_mask) == '0 |=> !o_alert)
		else $error("masked source drove the interrupt output");
	a_mask_throttle: assert property (
		wr_msk2 && !swrst_ff |=> msk2_ff[4:2] == $past(i_reg_wdata[4:2]))
		else $error("throttle mask bits not written");
	a_comp_unmasked: assert property (
		ev[`AFQ_SRC_THROTTLE_STATE] |=> o_alert_comp)
		else $error("throttle-state mask affected comparator output");
	a_local_high: assert property (
		i_local_temp_valid && (i_local_temp > lhl_ff) && !swrst_ff &&
		queue_len == 3'h1 |=> ev[0])
		else $error("local high status not set above limit");
	a_swrst_clears: assert property (
		swrst_ff |=> ev == '0)
		else $error("software reset did not clear status");
	a_alert_unmasked: assert property (
		(ev & ~src_mask) != '0 |=> o_alert)
		else $error("unmasked status did not raise interrupt output");
	a_comp_masked: assert property (
		(ev & ~comp_mask) == '0 |=> !o_alert_comp)
		else $error("comparator output set with all sources masked");
	a_drive_remote: assert property (
		(fan_ff[1:0] == 2'h1 || fan_ff[1:0] == 2'h2) |=>
		o_drive_remote && !o_drive_full)
		else $error("drive select 01 or 10 did not pick remote");
	a_drive_local: assert property (
		fan_ff[1:0] == 2'h0 |=> !o_drive_remote && !o_drive_full)
		else $error("drive select 00 did not pick local");
	a_fan_on_out: assert property (
		!fan_ff[`AFQ_BIT_FAN_OFF] |=> !o_fan_off)
		else $error("fan off output set with bit clear");
	a_fq_reserved: assert property (
		fq_ff[7:4] == 4'h0)
		else $error("fault queue reserved bits not zero");
endmodule // afq_alert_mask
`default_nettype wire

// [verilog/afq_consts.svh]
// Register offsets, field positions, reset values and write masks
`ifndef AFQ_CONSTS_SVH
`define AFQ_CONSTS_SVH

`define AFQ_ADDR_SWRST 8'h01
`define AFQ_ADDR_FQ 8'h06
`define AFQ_ADDR_FAN 8'h07
`define AFQ_ADDR_MSK1 8'h08
`define AFQ_ADDR_MSK2 8'h09
`define AFQ_ADDR_MSK3 8'h0A
`define AFQ_ADDR_LHL 8'h0B

`define AFQ_RST_FQ 8'h01
`define AFQ_RST_FAN 8'h09
`define AFQ_RST_MSK1 8'h52
`define AFQ_RST_MSK2 8'h10
`define AFQ_RST_MSK3 8'h00
`define AFQ_RST_LHL 8'h8B
`define AFQ_RD_ZERO 8'h00

`define AFQ_WM_FQ 8'h0F
`define AFQ_WM_FAN 8'h43
`define AFQ_WM_MSK1 8'hF8
`define AFQ_WM_MSK2 8'h1C
`define AFQ_WM_MSK3 8'hC0
`define AFQ_WM_LHL 8'hFF

`define AFQ_BIT_SWRST 0
`define AFQ_BIT_FAN_OFF 6
`define AFQ_NUM_SRC 10
`define AFQ_SRC_THROTTLE_STATE 7

`endif

// [verilog/afq_fault_counter.sv]
// Per-source consecutive out-of-limit counter
`timescale 1ns/1ps
`default_nettype none
module afq_fault_counter
	import afq_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_clear,
	input wire logic i_valid,
	input wire logic i_out_of_limit,
	input wire afq_count_t i_queue_len,
	output logic o_event
);
	afq_count_t cnt_ff;
	logic event_ff;
	wire afq_count_t cnt_inc = (cnt_ff >= i_queue_len) ? i_queue_len :
		afq_count_t'(cnt_ff + 3'h1);
	wire afq_count_t nxt_cnt = i_clear ? 3'h0 :
		!i_valid ? cnt_ff :
		i_out_of_limit ? cnt_inc : 3'h0;
	// Event moves only on a strobe or a clear, so a length change alone cannot raise it
	wire logic nxt_event = i_clear ? 1'b0 :
		!i_valid ? event_ff : (nxt_cnt == i_queue_len);

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_ff <= 3'h0;
			event_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			event_ff <= nxt_event;
		end
	end
	assign o_event = event_ff;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	a_event_needs_count: assert property (
		$rose(event_ff) && !$past(i_clear) |->
		$past(i_valid) && $past(i_out_of_limit) &&
		$past(cnt_ff) >= afq_count_t'($past(i_queue_len) - 3'h1))
		else $error("event raised before queue length reached");
	a_inlimit_clears: assert property (
		i_valid && !i_out_of_limit |=> cnt_ff == 3'h0 && !event_ff)
		else $error("in-limit measurement did not clear count");
endmodule // afq_fault_counter
`default_nettype wire

// [verilog/afq_pkg.sv]
// Types shared by the alert mask and fault queue block
package afq_pkg;
	typedef logic [7:0] afq_byte_t;
	typedef logic [2:0] afq_count_t;
	typedef enum logic [1:0] {
		AFQ_DRV_LOCAL = 2'h0,
		AFQ_DRV_REMOTE_A = 2'h1,
		AFQ_DRV_REMOTE_B = 2'h2,
		AFQ_DRV_FULL = 2'h3
	} afq_drive_src_t;
endpackage
